// File: core/slp_pkg.sv
// shared constants and types of the shift-left product unit
package slp_pkg;
    // register byte offsets
    localparam logic [7:0] SLP_CTRL = 8'h00;
    localparam logic [7:0] SLP_SHIFT = 8'h04;
    localparam logic [7:0] SLP_PHIGH = 8'h08;
    localparam logic [7:0] SLP_FLAGS = 8'h0c;
    localparam logic [7:0] SLP_APTR = 8'h10;
    localparam logic [7:0] SLP_AIDX = 8'h14;
    localparam logic [7:0] SLP_ACCP = 8'h18;
    localparam logic [7:0] SLP_ISTAT = 8'h1c;
    localparam logic [7:0] SLP_IMASK = 8'h20;
    localparam logic [1:0] SLP_ACC_WIN = 2'h1;
    // field positions
    localparam int SLP_SEXT_BIT = 0;
    localparam int SLP_IRQ_DONE = 0;
    localparam int SLP_IRQ_OVF = 1;
    // axi responses
    localparam logic [1:0] SLP_OKAY = 2'h0;
    localparam logic [1:0] SLP_SLVERR = 2'h2;
    // address step per data word and offset-accumulator flip
    localparam logic [15:0] SLP_PTR_STEP = 16'h0002;
    localparam logic [3:0] SLP_OFF_FLIP = 4'h8;
    // reset value of every state bit
    localparam logic SLP_RST_BIT = 1'b0;
    typedef enum logic [1:0] {
        SLP_OP_SUBW = 2'b00,
        SLP_OP_SUBC = 2'b01,
        SLP_OP_MOVW = 2'b10,
        SLP_OP_MOVC = 2'b11
    } slp_op_t;
    typedef enum logic [2:0] {
        SLP_AM_DIRECT = 3'b000,
        SLP_AM_REL = 3'b001,
        SLP_AM_IND = 3'b010,
        SLP_AM_POST = 3'b011,
        SLP_AM_INDEX = 3'b100
    } slp_amode_t;
    typedef enum logic [1:0] {
        SLP_ST_IDLE = 2'b00,
        SLP_ST_READ = 2'b01,
        SLP_ST_EXEC = 2'b10,
        SLP_ST_TAIL = 2'b11
    } slp_state_t;
endpackage : slp_pkg

// File: core/slp_shift_unit.sv
// shift-left product unit: subtract and transfer of shifted words and chains
// Functional notes
// - shift accumulator or memory operand left by the shift count register
// - zeros enter low end; high end zero or sign by sign-extend mode bit
// - word forms build a 32-bit shift; low 16 bits are the product-low value
// - upper 16 shifted bits latch into product-high register on every form
// - subtract forms write destination minus product-low value
// - transfer forms write product-low value into destination
// - subtract chain carries shifted-out bits into the next accumulator
// - subtract chain leaves a product-high copy in the accumulator after the chain
// - word transfer puts shifted-out bits into product-high register only
// - next-accumulator modifier on word forms bumps the pointer before reading and shifting
// - overflow, sign, zero and carry flags follow the arithmetic result
// - memory source updates the tag flag from the word read
// - extra word carries a direct address or a long relative offset
// - indirect reads at the pointer; post-increment adds two afterwards
// - indexed post-modify adds the index register into the pointer
// - transfer also offered as chain form over accumulators or memory
// - transfer chain also writes product-high into one accumulator past it
`timescale 1ns/1ps
`default_nettype none
module slp_shift_unit (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite register slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // instruction sequencer
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire slp_pkg::slp_op_t cmd_op,
    input wire logic cmd_mem,
    input wire logic [3:0] cmd_acc,
    input wire logic cmd_dst_off,
    input wire logic cmd_src_off,
    input wire logic cmd_next_acc,
    input wire slp_pkg::slp_amode_t cmd_amode,
    input wire logic [15:0] cmd_ext,
    input wire logic [3:0] cmd_len,
    output logic op_done,
    // data memory
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_rtag,
    // interrupt
    output logic irq
);
    import slp_pkg::*;

    typedef struct packed {
        slp_state_t st;
        logic [15:0][15:0] acc;
        logic [15:0] phigh;
        logic [3:0] shamt;
        logic sext;
        logic of;
        logic sgn;
        logic zero;
        logic cy;
        logic tag;
        logic [15:0] ptr;
        logic [15:0] idx;
        logic [3:0] accp;
        logic [1:0] ist;
        logic [1:0] imask;
        slp_op_t op;
        slp_amode_t am;
        logic mem;
        logic [3:0] dst;
        logic [3:0] src;
        logic [3:0] cnt;
        logic [3:0] left;
        logic [15:0] carry;
        logic brw;
        logic zacc;
        logic [15:0] word;
        logic done;
        logic mreq;
        logic [15:0] maddr;
        logic aw_ok;
        logic [7:0] awa;
        logic w_ok;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } slp_regs_t;

    slp_regs_t r;
    slp_regs_t next_r;

    // register read decode, returns hit flag and data
    function automatic logic [32:0] reg_read(input logic [7:0] a);
        logic [32:0] v;
        v = {1'b1, 32'h0};
        if (a[7:6] == SLP_ACC_WIN) begin
            v[15:0] = r.acc[a[5:2]];
        end else if (a == SLP_CTRL) begin
            v[SLP_SEXT_BIT] = r.sext;
        end else if (a == SLP_SHIFT) begin
            v[3:0] = r.shamt;
        end else if (a == SLP_PHIGH) begin
            v[15:0] = r.phigh;
        end else if (a == SLP_FLAGS) begin
            v[5:0] = {r.st != SLP_ST_IDLE, r.tag, r.cy, r.zero, r.sgn, r.of};
        end else if (a == SLP_APTR) begin
            v[15:0] = r.ptr;
        end else if (a == SLP_AIDX) begin
            v[15:0] = r.idx;
        end else if (a == SLP_ACCP) begin
            v[3:0] = r.accp;
        end else if (a == SLP_ISTAT) begin
            v[1:0] = r.ist;
        end else if (a == SLP_IMASK) begin
            v[1:0] = r.imask;
        end else begin
            v[32] = 1'b0;
        end
        return v;
    endfunction : reg_read

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[8*i +: 8] = d[8*i +: 8];
            end
        end
        return m;
    endfunction : merge

    // datapath of the current word
    logic last;
    logic sub;
    logic chain;
    logic [3:0] sidx;
    logic [3:0] widx;
    logic [15:0] w;
    logic extb;
    logic [31:0] sh32;
    logic [15:0] lo16;
    logic [15:0] aold;
    logic [16:0] dif;
    logic [15:0] res;
    logic ovf;
    assign last = (r.left == 4'h0);
    assign sub = (r.op == SLP_OP_SUBW) || (r.op == SLP_OP_SUBC);
    assign chain = r.op[0];
    assign sidx = 4'(r.src + r.cnt);
    assign widx = 4'(r.dst + r.cnt);
    assign w = r.mem ? r.word : r.acc[sidx];
    assign extb = r.sext & last & w[15];
    assign sh32 = {{16{extb}}, w} << r.shamt;
    assign lo16 = sh32[15:0] | r.carry;
    assign aold = r.acc[widx];
    assign dif = {1'b0, aold} - {1'b0, lo16} - {16'h0, r.brw};
    assign res = sub ? dif[15:0] : lo16;
    assign ovf = sub & (aold[15] != lo16[15]) & (res[15] != aold[15]);

    // handshakes and outputs
    assign awready = ce & ~r.aw_ok & ~r.bv;
    assign wready = ce & ~r.w_ok & ~r.bv;
    assign arready = ce & ~r.rv;
    assign bvalid = r.bv;
    assign bresp = r.br;
    assign rvalid = r.rv;
    assign rdata = r.rd;
    assign rresp = r.rr;
    assign cmd_ready = ce & (r.st == SLP_ST_IDLE);
    assign op_done = r.done;
    assign mem_req = r.mreq;
    assign mem_addr = r.maddr;
    assign irq = |(r.ist & r.imask);

    // next state
    always_comb begin
        logic [32:0] rv;
        logic [31:0] wv;
        logic [3:0] apn;
        logic [3:0] base;
        logic [15:0] nxt;
        rv = 33'h0;
        wv = 32'h0;
        apn = 4'h0;
        base = 4'h0;
        nxt = 16'h0;
        next_r = r;
        next_r.done = 1'b0;
        // register writes
        if (awvalid && awready) begin
            next_r.aw_ok = 1'b1;
            next_r.awa = awaddr;
        end
        if (wvalid && wready) begin
            next_r.w_ok = 1'b1;
            next_r.wd = wdata;
            next_r.ws = wstrb;
        end
        if (r.bv && bready) begin
            next_r.bv = 1'b0;
        end
        if (r.aw_ok && r.w_ok && !r.bv) begin
            rv = reg_read(r.awa);
            wv = merge(rv[31:0], r.wd, r.ws);
            next_r.aw_ok = 1'b0;
            next_r.w_ok = 1'b0;
            next_r.bv = 1'b1;
            next_r.br = rv[32] ? SLP_OKAY : SLP_SLVERR;
            if (r.awa[7:6] == SLP_ACC_WIN) begin
                next_r.acc[r.awa[5:2]] = wv[15:0];
            end else if (r.awa == SLP_CTRL) begin
                next_r.sext = wv[SLP_SEXT_BIT];
            end else if (r.awa == SLP_SHIFT) begin
                next_r.shamt = wv[3:0];
            end else if (r.awa == SLP_APTR) begin
                next_r.ptr = wv[15:0];
            end else if (r.awa == SLP_AIDX) begin
                next_r.idx = wv[15:0];
            end else if (r.awa == SLP_ACCP) begin
                next_r.accp = wv[3:0];
            end else if (r.awa == SLP_ISTAT) begin
                next_r.ist = r.ist & ~wv[1:0];
            end else if (r.awa == SLP_IMASK) begin
                next_r.imask = wv[1:0];
            end
        end
        // register reads
        if (r.rv && rready) begin
            next_r.rv = 1'b0;
        end
        if (arvalid && arready) begin
            rv = reg_read(araddr);
            next_r.rv = 1'b1;
            next_r.rd = rv[31:0];
            next_r.rr = rv[32] ? SLP_OKAY : SLP_SLVERR;
        end
        // engine, after bus writes so that it wins
        case (r.st)
            SLP_ST_IDLE: begin
                if (cmd_valid) begin
                    apn = 4'(r.accp + {3'h0, cmd_next_acc & ~cmd_op[0]});
                    next_r.accp = apn;
                    base = 4'(apn + cmd_acc);
                    next_r.dst = cmd_dst_off ? (base ^ SLP_OFF_FLIP) : base;
                    next_r.src = cmd_src_off ? (base ^ SLP_OFF_FLIP) : base;
                    next_r.op = cmd_op;
                    next_r.am = cmd_amode;
                    next_r.mem = cmd_mem;
                    next_r.cnt = 4'h0;
                    next_r.left = cmd_op[0] ? cmd_len : 4'h0;
                    next_r.carry = 16'h0;
                    next_r.brw = 1'b0;
                    next_r.zacc = 1'b1;
                    if (cmd_amode == SLP_AM_DIRECT) begin
                        next_r.maddr = cmd_ext;
                    end else if (cmd_amode == SLP_AM_REL) begin
                        next_r.maddr = 16'(r.ptr + cmd_ext);
                    end else begin
                        next_r.maddr = r.ptr;
                    end
                    next_r.mreq = cmd_mem;
                    next_r.st = cmd_mem ? SLP_ST_READ : SLP_ST_EXEC;
                end
            end
            SLP_ST_READ: begin
                if (mem_ack) begin
                    next_r.mreq = 1'b0;
                    next_r.word = mem_rdata;
                    next_r.tag = mem_rtag;
                    if (r.am == SLP_AM_INDEX) begin
                        nxt = 16'(r.maddr + r.idx);
                    end else begin
                        nxt = 16'(r.maddr + SLP_PTR_STEP);
                    end
                    if (r.am == SLP_AM_POST || r.am == SLP_AM_INDEX) begin
                        next_r.ptr = nxt;
                    end
                    next_r.maddr = nxt;
                    next_r.st = SLP_ST_EXEC;
                end
            end
            SLP_ST_EXEC: begin
                next_r.acc[widx] = res;
                next_r.carry = sh32[31:16];
                next_r.brw = sub & dif[16];
                next_r.zacc = r.zacc & (res == 16'h0);
                if (last) begin
                    next_r.phigh = sh32[31:16];
                    next_r.of = ovf;
                    next_r.sgn = res[15];
                    next_r.zero = r.zacc & (res == 16'h0);
                    next_r.cy = sub & dif[16];
                    if (ovf) begin
                        next_r.ist[SLP_IRQ_OVF] = 1'b1;
                    end
                    if (chain) begin
                        next_r.st = SLP_ST_TAIL;
                    end else begin
                        next_r.st = SLP_ST_IDLE;
                        next_r.done = 1'b1;
                        next_r.ist[SLP_IRQ_DONE] = 1'b1;
                    end
                end else begin
                    next_r.cnt = 4'(r.cnt + 4'h1);
                    next_r.left = 4'(r.left - 4'h1);
                    next_r.mreq = r.mem;
                    next_r.st = r.mem ? SLP_ST_READ : SLP_ST_EXEC;
                end
            end
            SLP_ST_TAIL: begin
                next_r.acc[4'(widx + 4'h1)] = r.phigh;
                next_r.st = SLP_ST_IDLE;
                next_r.done = 1'b1;
                next_r.ist[SLP_IRQ_DONE] = 1'b1;
            end
            default: begin
                next_r.st = SLP_ST_IDLE;
            end
        endcase
    end

    // state register, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= {$bits(slp_regs_t){SLP_RST_BIT}};
        end else if (ce) begin
            r <= next_r;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start_next;
        cmd_valid && cmd_ready && cmd_next_acc && !cmd_op[0];
    endsequence
    sequence s_acc_step;
        ce && r.st == SLP_ST_EXEC && !r.mem && !last;
    endsequence
    sequence s_mem_wait;
        ce && r.mreq && !mem_ack;
    endsequence

    chk_accp_premod: assert property (s_start_next |=> r.accp == 4'($past(r.accp) + 4'h1))
        else $error("pointer not advanced before shift");
    chk_fill_low: assert property (ce && r.st == SLP_ST_EXEC && !sub && !chain |=>
        (r.acc[$past(widx)] & 16'((17'h1 << $past(r.shamt)) - 17'h1)) == 16'h0)
        else $error("low end not zero filled");
    chk_phigh_latch: assert property (ce && r.st == SLP_ST_EXEC && last |=>
        r.phigh == $past(sh32[31:16]))
        else $error("product high not latched");
    chk_sub_wb: assert property (ce && r.st == SLP_ST_EXEC && sub |=>
        16'(r.acc[$past(widx)] + $past(lo16) + {15'h0, $past(r.brw)}) == $past(aold))
        else $error("subtract write back wrong");
    chk_move_wb: assert property (ce && r.st == SLP_ST_EXEC && !sub |=>
        r.acc[$past(widx)] == $past(lo16))
        else $error("transfer write back wrong");
    chk_chain_carry: assert property (s_acc_step |=>
        r.st == SLP_ST_EXEC && r.carry == $past(sh32[31:16]))
        else $error("chain carry lost");
    chk_tail_copy: assert property (ce && r.st == SLP_ST_TAIL |=>
        r.acc[4'($past(widx) + 4'h1)] == r.phigh && op_done)
        else $error("product high copy missing");
    chk_post_step: assert property (ce && r.st == SLP_ST_READ && mem_ack &&
        r.am == SLP_AM_POST |=> r.ptr == 16'($past(r.maddr) + SLP_PTR_STEP))
        else $error("post increment wrong");
    chk_index_step: assert property (ce && r.st == SLP_ST_READ && mem_ack &&
        r.am == SLP_AM_INDEX |=> r.ptr == 16'($past(r.maddr) + $past(r.idx)))
        else $error("indexed post modify wrong");
    chk_tag_take: assert property (ce && r.st == SLP_ST_READ && mem_ack |=>
        r.tag == $past(mem_rtag) && r.word == $past(mem_rdata))
        else $error("tag not taken from memory");
    chk_mem_hold: assert property (s_mem_wait |=> r.mreq && $stable(r.maddr))
        else $error("memory request dropped");
    chk_zero_flag: assert property (ce && r.st == SLP_ST_EXEC && last |=>
        r.zero == ($past(r.zacc) && $past(res) == 16'h0) && r.sgn == $past(res[15]))
        else $error("zero or sign flag wrong");
endmodule : slp_shift_unit
`default_nettype wire

// File: bench/slp_mem_model.sv
// data memory model answering reads after a programmable delay
`timescale 1ns/1ps
`default_nettype none
module slp_mem_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // read port
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    output logic mem_rtag,
    // answer delay in cycles
    input wire logic [3:0] lat
);
    logic [3:0] wait_cnt;

    // content follows the address; lines scramble outside the answer cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_cnt <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            mem_rtag <= 1'b0;
        end else if (mem_req && !mem_ack && wait_cnt == lat) begin
            wait_cnt <= 4'h0;
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr + 16'h1111;
            mem_rtag <= mem_addr[2];
        end else begin
            wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            mem_rtag <= ~mem_rtag;
        end
    end
endmodule : slp_mem_model
`default_nettype wire

// File: bench/slp_shift_unit_tb_top.sv
// self-checking bench of the shift-left product unit
`timescale 1ns/1ps
`default_nettype none
module slp_shift_unit_tb_top;
    import slp_pkg::*;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cmd_valid, cmd_ready, cmd_mem, op_done;
    logic cmd_dst_off, cmd_src_off, cmd_next_acc, mem_req, mem_ack, mem_rtag, irq, soff;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, cmd_acc, cmd_len, lat;
    logic [1:0] bresp, rresp, r;
    logic [15:0] cmd_ext, mem_addr, mem_rdata;
    slp_op_t cmd_op;
    slp_amode_t cmd_amode;
    int errors, total_checks;
    // addressing mode table
    slp_amode_t am_t [5] = '{SLP_AM_DIRECT, SLP_AM_REL, SLP_AM_IND, SLP_AM_POST, SLP_AM_INDEX};
    logic [15:0] ext_t [5] = '{16'h0404, 16'h0020, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] pl_t [5] = '{16'h5150, 16'h3310, 16'h3110, 16'h3110, 16'h3130};
    logic [15:0] ptr_t [5] = '{16'h0200, 16'h0200, 16'h0200, 16'h0202, 16'h0212};
    logic tag_t [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    // flag table: destination, source, result, flags
    logic [15:0] fd_t [3] = '{16'h2340, 16'h0000, 16'h8000};
    logic [15:0] fs_t [3] = '{16'h2340, 16'h0010, 16'h0001};
    logic [15:0] fr_t [3] = '{16'h0000, 16'hfff0, 16'h7fff};
    logic [31:0] ff_t [3] = '{32'h4, 32'ha, 32'h1};

    slp_shift_unit slp_shift_unit_i (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .cmd_valid, .cmd_ready, .cmd_op, .cmd_mem,
        .cmd_acc, .cmd_dst_off, .cmd_src_off, .cmd_next_acc, .cmd_amode, .cmd_ext, .cmd_len,
        .op_done, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .mem_rtag, .irq);
    slp_mem_model slp_mem_model_i (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ack,
        .mem_rdata, .mem_rtag, .lat);

    // 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic timeout_hit();
        errors++;
        finish_test();
    endtask : timeout_hit

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] got;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_ok = 1'b0;
        n = 0;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            got = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            n++;
            if (n > 100) timeout_hit();
        end
        bready <= 1'b0;
        check(got, er);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        logic ar_ok, r_ok;
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_ok = 1'b0;
        n = 0;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            v = rdata;
            rr = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            n++;
            if (n > 100) timeout_hit();
        end
        rready <= 1'b0;
    endtask : axi_read

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rr;
        axi_read(a, v, rr);
        check(rr, SLP_OKAY);
        check(v, e);
    endtask : rd_chk

    task automatic acc_w(input logic [3:0] i, input logic [15:0] v);
        axi_write(8'h40 + {2'b00, i, 2'b00}, {16'h0000, v}, SLP_OKAY);
    endtask : acc_w

    task automatic acc_r(input logic [3:0] i, input logic [15:0] v);
        rd_chk(8'h40 + {2'b00, i, 2'b00}, {16'h0000, v});
    endtask : acc_r

    task automatic irq_chk(input logic e);
        @(negedge aclk);
        check(irq, e);
    endtask : irq_chk

    // offer a command, wait for acceptance and for completion
    task automatic run_cmd(input slp_op_t op, input logic mem, input logic [3:0] acc,
        input logic doff, input logic nxt, input slp_amode_t am, input logic [15:0] ext,
        input logic [3:0] len);
        logic ok;
        int n;
        @(posedge aclk);
        cmd_op <= op;
        cmd_mem <= mem;
        cmd_acc <= acc;
        cmd_dst_off <= doff;
        cmd_src_off <= soff;
        cmd_next_acc <= nxt;
        cmd_amode <= am;
        cmd_ext <= ext;
        cmd_len <= len;
        cmd_valid <= 1'b1;
        ok = 1'b0;
        n = 0;
        while (!ok) begin
            @(negedge aclk);
            ok = cmd_ready;
            @(posedge aclk);
            n++;
            if (n > 100) timeout_hit();
        end
        cmd_valid <= 1'b0;
        ok = 1'b0;
        n = 0;
        while (!ok) begin
            @(negedge aclk);
            ok = op_done;
            n++;
            if (n > 200) timeout_hit();
        end
    endtask : run_cmd

    // main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cmd_valid} = '0;
        {cmd_mem, cmd_dst_off, cmd_src_off, cmd_next_acc, soff} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        cmd_op = SLP_OP_SUBW;
        cmd_amode = SLP_AM_DIRECT;
        {cmd_acc, cmd_len, lat, cmd_ext} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, unmapped and read-only places
        rd_chk(SLP_CTRL, 32'h0);
        rd_chk(SLP_PHIGH, 32'h0);
        rd_chk(SLP_FLAGS, 32'h0);
        axi_read(8'h24, d, r);
        check(r, SLP_SLVERR);
        check(d, 32'h0);
        axi_write(8'h24, 32'h1, SLP_SLVERR);
        axi_write(SLP_PHIGH, 32'h1234, SLP_OKAY);
        rd_chk(SLP_PHIGH, 32'h0);
        // word subtract from the offset accumulator
        acc_w(4'h1, 16'h1234);
        acc_w(4'h9, 16'h5000);
        axi_write(SLP_SHIFT, 32'h4, SLP_OKAY);
        run_cmd(SLP_OP_SUBW, 1'b0, 4'h1, 1'b1, 1'b0, SLP_AM_DIRECT, 16'h0, 4'h0);
        acc_r(4'h9, 16'h2cc0);
        rd_chk(SLP_PHIGH, 32'h0001);
        rd_chk(SLP_FLAGS, 32'h0);
        // flag cases: zero, borrow with sign, overflow
        axi_write(SLP_SHIFT, 32'h0, SLP_OKAY);
        for (int k = 0; k < 3; k++) begin
            acc_w(4'hb, fd_t[k]);
            acc_w(4'h3, fs_t[k]);
            run_cmd(SLP_OP_SUBW, 1'b0, 4'h3, 1'b1, 1'b0, SLP_AM_DIRECT, 16'h0, 4'h0);
            acc_r(4'hb, fr_t[k]);
            rd_chk(SLP_FLAGS, ff_t[k]);
        end
        // byte strobes: only the low lane lands
        wstrb <= 4'h1;
        acc_w(4'h3, 16'hffff);
        wstrb <= 4'hf;
        acc_r(4'h3, 16'h00ff);
        // interrupt raised, masked and cleared
        rd_chk(SLP_ISTAT, 32'h3);
        irq_chk(1'b0);
        axi_write(SLP_IMASK, 32'h1, SLP_OKAY);
        irq_chk(1'b1);
        axi_write(SLP_ISTAT, 32'h1, SLP_OKAY);
        irq_chk(1'b0);
        rd_chk(SLP_ISTAT, 32'h2);
        axi_write(SLP_ISTAT, 32'h2, SLP_OKAY);
        rd_chk(SLP_ISTAT, 32'h0);
        // transfer with sign-extended and zero-filled high end
        axi_write(SLP_SHIFT, 32'h4, SLP_OKAY);
        axi_write(SLP_CTRL, 32'h1, SLP_OKAY);
        acc_w(4'h1, 16'h8001);
        run_cmd(SLP_OP_MOVW, 1'b0, 4'h1, 1'b1, 1'b0, SLP_AM_DIRECT, 16'h0, 4'h0);
        acc_r(4'h9, 16'h0010);
        rd_chk(SLP_PHIGH, 32'hfff8);
        axi_read(SLP_FLAGS, d, r);
        check(d & 32'h9, 32'h0);
        axi_write(SLP_CTRL, 32'h0, SLP_OKAY);
        run_cmd(SLP_OP_MOVW, 1'b0, 4'h1, 1'b1, 1'b0, SLP_AM_DIRECT, 16'h0, 4'h0);
        rd_chk(SLP_PHIGH, 32'h0008);
        // next-accumulator modifier moves the pointer first
        axi_write(SLP_SHIFT, 32'h0, SLP_OKAY);
        acc_w(4'h1, 16'h0005);
        acc_w(4'h2, 16'h0003);
        acc_w(4'ha, 16'h0100);
        run_cmd(SLP_OP_SUBW, 1'b0, 4'h1, 1'b1, 1'b1, SLP_AM_DIRECT, 16'h0, 4'h0);
        acc_r(4'ha, 16'h00fd);
        rd_chk(SLP_ACCP, 32'h1);
        axi_write(SLP_ACCP, 32'h0, SLP_OKAY);
        // source taken from the offset accumulator
        soff <= 1'b1;
        run_cmd(SLP_OP_MOVW, 1'b0, 4'h2, 1'b0, 1'b0, SLP_AM_DIRECT, 16'h0, 4'h0);
        soff <= 1'b0;
        acc_r(4'h2, 16'h00fd);
        // two-word subtract chain over accumulators
        axi_write(SLP_SHIFT, 32'h4, SLP_OKAY);
        acc_w(4'h0, 16'hf123);
        acc_w(4'h1, 16'h8456);
        acc_w(4'h8, 16'h3000);
        acc_w(4'h9, 16'h5000);
        run_cmd(SLP_OP_SUBC, 1'b0, 4'h0, 1'b1, 1'b0, SLP_AM_DIRECT, 16'h0, 4'h1);
        acc_r(4'h8, 16'h1dd0);
        acc_r(4'h9, 16'h0a91);
        acc_r(4'ha, 16'h0008);
        rd_chk(SLP_PHIGH, 32'h0008);
        // two-word transfer chain from memory, slow answers
        lat <= 4'h2;
        run_cmd(SLP_OP_MOVC, 1'b1, 4'h4, 1'b0, 1'b0, SLP_AM_DIRECT, 16'h0300, 4'h1);
        acc_r(4'h4, 16'h4110);
        acc_r(4'h5, 16'h4131);
        acc_r(4'h6, 16'h0001);
        // every addressing mode, prompt to slow memory
        axi_write(SLP_APTR, 32'h0200, SLP_OKAY);
        axi_write(SLP_AIDX, 32'h0010, SLP_OKAY);
        for (int k = 0; k < 5; k++) begin
            lat <= 4'(k);
            run_cmd(SLP_OP_MOVW, 1'b1, 4'h5, 1'b0, 1'b0, am_t[k], ext_t[k], 4'h0);
            acc_r(4'h5, pl_t[k]);
            rd_chk(SLP_APTR, {16'h0000, ptr_t[k]});
            axi_read(SLP_FLAGS, d, r);
            check(d[4], tag_t[k]);
        end
        finish_test();
    end
endmodule : slp_shift_unit_tb_top
`default_nettype wire
